// ==== nor_timing_pkg.sv ====
package nor_timing_pkg;

  // ---------------------------------------------------------------
  // field widths
  // ---------------------------------------------------------------
  localparam int TIME_W  = 5;
  localparam int SCALE_W = 2;
  localparam int DIV_W   = 2;
  localparam int BURST_W = 2;
  localparam int CNT_W   = 12;
  localparam int UNITS_W = 7;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  // one functional clock cycle is two clk_sys cycles, so a half cycle is one clk_sys cycle
  localparam logic [3:0]       HALF_PER_CYCLE = 4'h2;
  localparam logic [CNT_W-1:0] CNT_RESET      = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE        = 12'h001;
  localparam logic [DIV_W-1:0] DIV_RESET      = 2'h0;
  localparam logic [BURST_W-1:0] IDX_RESET    = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [TIME_W-1:0]  select_assert_time;
    logic [TIME_W-1:0]  select_read_deassert_time;
    logic [TIME_W-1:0]  select_write_deassert_time;
    logic               select_half_cycle_delay;
    logic [TIME_W-1:0]  latch_assert_time;
    logic [TIME_W-1:0]  latch_read_deassert_time;
    logic [TIME_W-1:0]  latch_write_deassert_time;
    logic               latch_half_cycle_delay;
    logic [TIME_W-1:0]  read_strobe_assert_time;
    logic [TIME_W-1:0]  read_strobe_deassert_time;
    logic               read_strobe_half_cycle_delay;
    logic [TIME_W-1:0]  write_strobe_assert_time;
    logic [TIME_W-1:0]  write_strobe_deassert_time;
    logic               write_strobe_half_cycle_delay;
    logic [TIME_W-1:0]  page_word_interval;
    logic [SCALE_W-1:0] timing_scale_select;
    logic [TIME_W-1:0]  inter_access_gap;
    logic [TIME_W-1:0]  read_cycle_length;
    logic [TIME_W-1:0]  write_cycle_length;
    logic [TIME_W-1:0]  read_sample_delay;
    logic [DIV_W-1:0]   ext_clock_divider;
  } timing_cfg_s;

  // edge times of one access, in clk_sys cycles from access start
  typedef struct packed {
    logic [CNT_W-1:0] cs_on;
    logic [CNT_W-1:0] cs_off;
    logic [CNT_W-1:0] adv_on;
    logic [CNT_W-1:0] adv_off;
    logic [CNT_W-1:0] oe_on;
    logic [CNT_W-1:0] oe_off;
    logic [CNT_W-1:0] we_on;
    logic [CNT_W-1:0] we_off;
    logic [CNT_W-1:0] be_end;
    logic [CNT_W-1:0] first_sample;
    logic [CNT_W-1:0] page_step;
    logic [CNT_W-1:0] gap_len;
  } event_times_s;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_GAP    = 2'b11
  } access_state_e;

endpackage

// ==== async_nor_strobe_timing.sv ====
// Functional notes
// [RULE1] single access select width from off minus on
// [RULE2] burst read widens select by page intervals
// [RULE3] burst write widens select likewise
// [RULE4] read latch deassert time with half cycles
// [RULE5] write latch deassert uses write time
// [RULE6] single read strobe deassert time
// [RULE7] burst read strobe deassert adds page intervals
// [RULE8] page addresses held one page interval each
// [RULE9] write strobe assert time after select
// [RULE10] write strobe deassert time after select
// [RULE11] address invalid for unscaled gap cycles; the code scales the gap by setting+1
// [RULE12] select asserts after scaled on time
// [RULE13] latch asserts at scaled time after select
// [RULE14] read strobe asserts at scaled time
// [RULE15] byte enables valid for cycle length
// [RULE16] burst extends byte enables by page intervals
// [RULE17] divider zero gives memory clock full rate
// [RULE18] scale select multiplies times by setting+1
// [RULE19] read data sampled after sample delay
// [RULE20] four independent chip selects with own timing
// [RULE21] next page word sampled per page interval
// [RULE22] one counter drives every strobe edge
// [RULE23] memory holds read data until strobe ends
`timescale 1ns/10ps
`default_nettype none

module async_nor_strobe_timing #(
  parameter int NUM_CS    = 4,
  parameter int ADDR_W    = 26,
  parameter int DATA_W    = 16,
  parameter int MAX_BURST = 4
) (
  input  wire  logic                                      clk_sys,
  input  wire  logic                                      reset_n,
  input  wire  nor_timing_pkg::timing_cfg_s [NUM_CS-1:0]  cfg,
  input  wire  logic                                      req_valid,
  input  wire  logic                                      req_write,
  input  wire  logic [1:0]                                req_cs,
  input  wire  logic [ADDR_W-1:0]                         req_addr,
  input  wire  logic [nor_timing_pkg::BURST_W-1:0]        req_burst_m1,
  input  wire  logic [1:0]                                req_byte_en,
  input  wire  logic [MAX_BURST-1:0][DATA_W-1:0]          req_wdata,
  output logic                                            req_ready,
  output logic [NUM_CS-1:0]                               chip_select_n,
  output logic                                            addr_valid_latch_n,
  output logic                                            output_enable_n,
  output logic                                            write_enable_n,
  output logic                                            low_byte_enable_n,
  output logic                                            high_byte_enable_n,
  output logic [ADDR_W-1:0]                               ext_address,
  input  wire  logic [DATA_W-1:0]                         ext_addr_data_bus_in,
  output logic [DATA_W-1:0]                               ext_addr_data_bus_out,
  output logic                                            ext_addr_data_bus_oe,
  output logic                                            ext_memory_clock,
  output logic [DATA_W-1:0]                               rd_data,
  output logic                                            rd_valid,
  output logic [nor_timing_pkg::BURST_W-1:0]              rd_index,
  output logic                                            access_done
);
  import nor_timing_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NUM_CS != 4) begin : g_cs_check
    $error("select decode serves exactly four chip selects");
  end
  if (MAX_BURST != 4) begin : g_burst_check
    $error("page index width serves bursts of up to four words");
  end
  if (DATA_W < 2 || ADDR_W < 2) begin : g_width_check
    $error("bus widths too small");
  end

  // ---------------------------------------------------------------
  // edge time arithmetic
  // ---------------------------------------------------------------
  // units are functional cycles; result is clk_sys cycles (half functional cycles)
  function automatic logic [CNT_W-1:0] to_half(input logic [UNITS_W-1:0] units,
                                               input logic [3:0]         scale,
                                               input logic               half);
    logic [CNT_W-1:0] prod;
    prod = {{(CNT_W-UNITS_W){1'b0}}, units} * {{(CNT_W-4){1'b0}}, scale};
    return prod + {{(CNT_W-1){1'b0}}, half};
  endfunction

  function automatic logic [UNITS_W-1:0] widen(input logic [TIME_W-1:0]  base,
                                               input logic [BURST_W-1:0] extra_words,
                                               input logic [TIME_W-1:0]  page);
    logic [UNITS_W-1:0] extra;
    extra = {{(UNITS_W-BURST_W){1'b0}}, extra_words} * {{(UNITS_W-TIME_W){1'b0}}, page};
    return {{(UNITS_W-TIME_W){1'b0}}, base} + extra;
  endfunction

  timing_cfg_s  sel_cfg;
  logic [3:0]   sel_scale;
  event_times_s nxt_ev;

  always_comb begin
    sel_cfg   = cfg[req_cs];
    // scale select 0 gives x1; halves double it
    sel_scale = 4'(({2'b00, sel_cfg.timing_scale_select} + 4'h1) * HALF_PER_CYCLE); // [RULE18]
    nxt_ev.cs_on  = to_half(widen(sel_cfg.select_assert_time, IDX_RESET, sel_cfg.page_word_interval),
                            sel_scale, sel_cfg.select_half_cycle_delay); // [RULE12]
    if (req_write) begin
      nxt_ev.cs_off  = to_half(widen(sel_cfg.select_write_deassert_time, req_burst_m1,
                                     sel_cfg.page_word_interval),
                               sel_scale, sel_cfg.select_half_cycle_delay); // [RULE1] [RULE3]
      nxt_ev.adv_off = to_half(widen(sel_cfg.latch_write_deassert_time, IDX_RESET, sel_cfg.page_word_interval),
                               sel_scale, sel_cfg.latch_half_cycle_delay); // [RULE5]
      nxt_ev.be_end  = to_half(widen(sel_cfg.write_cycle_length, req_burst_m1, sel_cfg.page_word_interval),
                               sel_scale, 1'b0); // [RULE15] [RULE16]
    end else begin
      nxt_ev.cs_off  = to_half(widen(sel_cfg.select_read_deassert_time, req_burst_m1,
                                     sel_cfg.page_word_interval),
                               sel_scale, sel_cfg.select_half_cycle_delay); // [RULE1] [RULE2]
      nxt_ev.adv_off = to_half(widen(sel_cfg.latch_read_deassert_time, IDX_RESET, sel_cfg.page_word_interval),
                               sel_scale, sel_cfg.latch_half_cycle_delay); // [RULE4]
      nxt_ev.be_end  = to_half(widen(sel_cfg.read_cycle_length, req_burst_m1, sel_cfg.page_word_interval),
                               sel_scale, 1'b0); // [RULE15] [RULE16]
    end
    nxt_ev.adv_on  = to_half(widen(sel_cfg.latch_assert_time, IDX_RESET, sel_cfg.page_word_interval),
                             sel_scale, sel_cfg.latch_half_cycle_delay); // [RULE13]
    nxt_ev.oe_on   = to_half(widen(sel_cfg.read_strobe_assert_time, IDX_RESET, sel_cfg.page_word_interval),
                             sel_scale, sel_cfg.read_strobe_half_cycle_delay); // [RULE14]
    nxt_ev.oe_off  = to_half(widen(sel_cfg.read_strobe_deassert_time, req_burst_m1, sel_cfg.page_word_interval),
                             sel_scale, sel_cfg.read_strobe_half_cycle_delay); // [RULE6] [RULE7]
    nxt_ev.we_on   = to_half(widen(sel_cfg.write_strobe_assert_time, IDX_RESET, sel_cfg.page_word_interval),
                             sel_scale, sel_cfg.write_strobe_half_cycle_delay); // [RULE9]
    nxt_ev.we_off  = to_half(widen(sel_cfg.write_strobe_deassert_time, IDX_RESET, sel_cfg.page_word_interval),
                             sel_scale, sel_cfg.write_strobe_half_cycle_delay); // [RULE10]
    nxt_ev.first_sample = to_half(widen(sel_cfg.read_sample_delay, IDX_RESET, sel_cfg.page_word_interval),
                                  sel_scale, 1'b0); // [RULE19]
    nxt_ev.page_step    = to_half(widen(sel_cfg.page_word_interval, IDX_RESET, sel_cfg.page_word_interval),
                                  sel_scale, 1'b0); // [RULE8] [RULE21]
    // gap scales too, so it never falls below the unscaled minimum
    nxt_ev.gap_len = to_half(widen(sel_cfg.inter_access_gap, IDX_RESET, sel_cfg.page_word_interval),
                             sel_scale, 1'b0); // [RULE11] [RULE18]
  end

  // ---------------------------------------------------------------
  // access sequencing
  // ---------------------------------------------------------------
  access_state_e                 state_ff;
  access_state_e                 nxt_state;
  event_times_s                  ev_ff;
  logic [CNT_W-1:0]              cnt_ff;
  logic [CNT_W-1:0]              next_sample_ff;
  logic [BURST_W-1:0]            page_idx_ff;
  logic [BURST_W-1:0]            burst_m1_ff;
  logic                          write_ff;
  logic [1:0]                    cs_sel_ff;
  logic [ADDR_W-1:0]             addr_base_ff;
  logic [1:0]                    byte_en_ff;
  logic [MAX_BURST-1:0][DATA_W-1:0] wdata_ff;
  logic                          req_ready_ff;
  logic                          accept;
  logic                          active_end;
  logic                          gap_end;
  logic                          sample_hit;
  logic                          words_left_ff;

  assign accept     = req_valid && req_ready_ff;
  assign active_end = (cnt_ff + CNT_ONE) >= ev_ff.be_end;
  assign gap_end    = (cnt_ff + CNT_ONE) >= ev_ff.gap_len;
  assign sample_hit = (state_ff == ST_ACTIVE) && words_left_ff && (cnt_ff == next_sample_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (active_end) begin
          nxt_state = (ev_ff.gap_len == CNT_RESET) ? ST_IDLE : ST_GAP;
        end
      end
      ST_GAP: begin
        if (gap_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= ST_IDLE;
      req_ready_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      req_ready_ff <= (nxt_state == ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ev_ff        <= '0;
      write_ff     <= 1'b0;
      cs_sel_ff    <= 2'h0;
      addr_base_ff <= '0;
      burst_m1_ff  <= IDX_RESET;
      byte_en_ff   <= 2'h0;
      wdata_ff     <= '0;
    end else if (accept) begin
      ev_ff        <= nxt_ev;
      write_ff     <= req_write;
      cs_sel_ff    <= req_cs;
      addr_base_ff <= req_addr;
      burst_m1_ff  <= req_burst_m1;
      byte_en_ff   <= req_byte_en;
      wdata_ff     <= req_wdata;
    end
  end

  // single timeline counter; restarts at each access and each gap
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= CNT_RESET;
    end else if (state_ff != nxt_state) begin
      cnt_ff <= CNT_RESET; // [RULE22]
    end else if (state_ff != ST_IDLE) begin
      cnt_ff <= cnt_ff + CNT_ONE; // [RULE22]
    end
  end

  // page word scheduling, used for write bursts as well as reads
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      page_idx_ff    <= IDX_RESET;
      next_sample_ff <= CNT_RESET;
      words_left_ff  <= 1'b0;
    end else if (accept) begin
      page_idx_ff    <= IDX_RESET;
      next_sample_ff <= nxt_ev.first_sample; // [RULE19]
      words_left_ff  <= 1'b1;
    end else if (sample_hit) begin
      next_sample_ff <= next_sample_ff + ev_ff.page_step; // [RULE21]
      if (page_idx_ff == burst_m1_ff) begin
        words_left_ff <= 1'b0;
      end else begin
        page_idx_ff <= page_idx_ff + 2'h1; // [RULE8]
      end
    end
  end

  // ---------------------------------------------------------------
  // strobe outputs
  // ---------------------------------------------------------------
  // every strobe pin lags the counter by one register, so relative edge spacing is exact
  logic active;
  logic in_cs;
  logic in_adv;
  logic in_oe;
  logic in_we;

  always_comb begin
    active = (state_ff == ST_ACTIVE);
    in_cs  = active && (cnt_ff >= ev_ff.cs_on)  && (cnt_ff < ev_ff.cs_off);
    in_adv = active && (cnt_ff >= ev_ff.adv_on) && (cnt_ff < ev_ff.adv_off);
    in_oe  = active && !write_ff && (cnt_ff >= ev_ff.oe_on) && (cnt_ff < ev_ff.oe_off);
    in_we  = active && write_ff && (cnt_ff >= ev_ff.we_on) && (cnt_ff < ev_ff.we_off);
  end

  for (genvar i = 0; i < NUM_CS; i++) begin : g_select
    logic cs_n_ff;
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        cs_n_ff <= 1'b1;
      end else begin
        cs_n_ff <= !(in_cs && (cs_sel_ff == 2'(i))); // [RULE20] [RULE1]
      end
    end
    assign chip_select_n[i] = cs_n_ff;
  end

  logic              adv_n_ff;
  logic              oe_n_ff;
  logic              we_n_ff;
  logic              be_lo_n_ff;
  logic              be_hi_n_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] dout_ff;
  logic              doe_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      adv_n_ff <= 1'b1;
      oe_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
    end else begin
      adv_n_ff <= !in_adv; // [RULE13] [RULE4] [RULE5]
      oe_n_ff  <= !in_oe;  // [RULE14] [RULE6] [RULE7]
      we_n_ff  <= !in_we;  // [RULE9] [RULE10]
    end
  end

  // address and byte enables valid from access start to cycle end; address zero and byte enables high in the gap
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      be_lo_n_ff <= 1'b1;
      be_hi_n_ff <= 1'b1;
      addr_ff    <= '0;
    end else begin
      be_lo_n_ff <= !(active && byte_en_ff[0]); // [RULE15] [RULE16]
      be_hi_n_ff <= !(active && byte_en_ff[1]); // [RULE15] [RULE16]
      addr_ff    <= active ? addr_base_ff + ADDR_W'(page_idx_ff) : '0; // [RULE8] [RULE11]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dout_ff <= '0;
      doe_ff  <= 1'b0;
    end else begin
      dout_ff <= wdata_ff[page_idx_ff];
      doe_ff  <= active && write_ff;
    end
  end

  // ---------------------------------------------------------------
  // read capture
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]  rd_data_ff;
  logic               rd_valid_ff;
  logic [BURST_W-1:0] rd_index_ff;
  logic               done_ff;

  // relies on the memory holding data from the sample point until its strobe ends
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
      rd_index_ff <= IDX_RESET;
    end else begin
      rd_valid_ff <= sample_hit && !write_ff;
      if (sample_hit && !write_ff) begin
        rd_data_ff  <= ext_addr_data_bus_in; // [RULE19] [RULE21] [RULE23]
        rd_index_ff <= page_idx_ff;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= active && active_end;
    end
  end

  // ---------------------------------------------------------------
  // external memory clock
  // ---------------------------------------------------------------
  // free running; divider of the last accepted chip select applies
  logic [DIV_W-1:0] div_sel_ff;
  logic [DIV_W-1:0] div_cnt_ff;
  logic             mclk_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_sel_ff <= DIV_RESET;
      div_cnt_ff <= DIV_RESET;
      mclk_ff    <= 1'b0;
    end else begin
      if (accept) begin
        div_sel_ff <= sel_cfg.ext_clock_divider;
      end
      if (div_cnt_ff >= div_sel_ff) begin
        div_cnt_ff <= DIV_RESET;
        mclk_ff    <= !mclk_ff; // [RULE17]
      end else begin
        div_cnt_ff <= div_cnt_ff + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // output wiring
  // ---------------------------------------------------------------
  assign req_ready             = req_ready_ff;
  assign addr_valid_latch_n    = adv_n_ff;
  assign output_enable_n       = oe_n_ff;
  assign write_enable_n        = we_n_ff;
  assign low_byte_enable_n     = be_lo_n_ff;
  assign high_byte_enable_n    = be_hi_n_ff;
  assign ext_address           = addr_ff;
  assign ext_addr_data_bus_out = dout_ff;
  assign ext_addr_data_bus_oe  = doe_ff;
  assign ext_memory_clock      = mclk_ff;
  assign rd_data               = rd_data_ff;
  assign rd_valid              = rd_valid_ff;
  assign rd_index              = rd_index_ff;
  assign access_done           = done_ff;

endmodule

`default_nettype wire

// ==== nor_strobe_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module nor_strobe_checker #(
  parameter int NUM_CS = 4
) (
  input wire logic                                     clk_sys,
  input wire logic                                     reset_n,
  input wire nor_timing_pkg::timing_cfg_s [NUM_CS-1:0] cfg,
  input wire logic                                     req_valid,
  input wire logic                                     req_ready,
  input wire logic [NUM_CS-1:0]                        chip_select_n,
  input wire logic                                     addr_valid_latch_n,
  input wire logic                                     output_enable_n,
  input wire logic                                     write_enable_n,
  input wire logic                                     low_byte_enable_n,
  input wire logic                                     high_byte_enable_n,
  input wire logic                                     ext_addr_data_bus_oe,
  input wire logic                                     ext_memory_clock,
  input wire logic                                     rd_valid,
  input wire logic                                     access_done
);
  logic div_nonzero;
  always_comb begin
    div_nonzero = 1'b0;
    for (int k = 0; k < NUM_CS; k++) div_nonzero |= (cfg[k].ext_clock_divider != 2'h0);
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_accept;
    req_valid && req_ready;
  endsequence
  sequence s_busy2;
    !req_ready [*2];
  endsequence
  a_accept_busy: assert property (s_accept |=> s_busy2)
    else $error("ready stayed high after accept");
  a_accept_done: assert property (s_accept |-> ##[2:600] access_done)
    else $error("access never completed");
  a_select_onehot: assert property ($onehot0(~chip_select_n))
    else $error("more than one select active");
  a_idle_quiet: assert property (req_ready |-> &chip_select_n && addr_valid_latch_n && output_enable_n
    && write_enable_n && low_byte_enable_n && high_byte_enable_n)
    else $error("strobe active while idle");
  a_read_no_drive: assert property (!output_enable_n |-> !ext_addr_data_bus_oe)
    else $error("bus driven during read strobe");
  a_write_drives: assert property (!write_enable_n |-> ext_addr_data_bus_oe && output_enable_n)
    else $error("write strobe without driven bus");
  a_done_pulse: assert property (access_done |=> !access_done)
    else $error("done longer than one cycle");
  a_rd_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");
  a_clock_full: assert property (!div_nonzero ##1 !div_nonzero |-> ext_memory_clock != $past(ext_memory_clock))
    else $error("memory clock not at full rate");
endmodule
bind async_nor_strobe_timing nor_strobe_checker #(.NUM_CS(NUM_CS)) i_chk (.clk_sys, .reset_n, .cfg,
  .req_valid, .req_ready, .chip_select_n, .addr_valid_latch_n, .output_enable_n, .write_enable_n,
  .low_byte_enable_n, .high_byte_enable_n, .ext_addr_data_bus_oe, .ext_memory_clock, .rd_valid, .access_done);
`default_nettype wire

// ==== nor_flash_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module nor_flash_model (
  input wire logic         clk_sys,
  input wire logic [3:0]   chip_select_n,
  input wire logic         output_enable_n,
  input wire logic         write_enable_n,
  input wire logic [25:0]  ext_address,
  input wire logic [15:0]  ext_addr_data_bus_out,
  output var logic [15:0]  ext_addr_data_bus_in = 16'h0,
  output var logic [15:0]  wr_data = 16'h0
);
  logic we_ff = 1'b1;
  always @(posedge clk_sys) begin
    // released bus toggles so a late sample cannot pass by luck
    if (chip_select_n != 4'hf && !output_enable_n) ext_addr_data_bus_in <= ext_address[15:0] ^ 16'ha5c3;
    else ext_addr_data_bus_in <= ~ext_addr_data_bus_in;
    if (!we_ff && write_enable_n) wr_data <= ext_addr_data_bus_out;
    we_ff <= write_enable_n;
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import nor_timing_pkg::*;
  logic clk_sys, reset_n, req_valid, req_write, req_ready, rd_valid, access_done, oe, mclk;
  logic addr_valid_latch_n, output_enable_n, write_enable_n, low_byte_enable_n, high_byte_enable_n;
  logic [1:0] req_cs, req_burst_m1, req_byte_en, rd_index;
  logic [3:0] chip_select_n, cs_seen;
  logic [25:0] req_addr, ext_address, p_ad;
  logic [3:0][15:0] req_wdata;
  logic [15:0] bus_in, bus_out, rd_data, wr_data, rdq[4];
  timing_cfg_s [3:0] cfg;
  logic [4:0] s, p_s = 5'h1f;
  int cyc, na, gap_seen, fail_count, n_checks;
  int tf[5], tr[5], t_ad[8];
  async_nor_strobe_timing i_dut (.clk_sys, .reset_n, .cfg, .req_valid, .req_write, .req_cs, .req_addr,
    .req_burst_m1, .req_byte_en, .req_wdata, .req_ready, .chip_select_n, .addr_valid_latch_n,
    .output_enable_n, .write_enable_n, .low_byte_enable_n, .high_byte_enable_n, .ext_address,
    .ext_addr_data_bus_in(bus_in), .ext_addr_data_bus_out(bus_out), .ext_addr_data_bus_oe(oe),
    .ext_memory_clock(mclk), .rd_data, .rd_valid, .rd_index, .access_done);
  nor_flash_model i_mem (.clk_sys, .chip_select_n, .output_enable_n, .write_enable_n, .ext_address,
    .ext_addr_data_bus_out(bus_out), .ext_addr_data_bus_in(bus_in), .wr_data);
  // ----------------------------------------
  // edge monitor: 4 select, 3 latch, 2 oe, 1 we, 0 byte enable
  // ----------------------------------------
  assign s = {&chip_select_n, addr_valid_latch_n, output_enable_n, write_enable_n, low_byte_enable_n};
  always @(posedge clk_sys) begin
    cyc++;
    for (int j = 0; j < 5; j++) begin
      if (p_s[j] && !s[j]) begin
        if (j == 0) gap_seen = cyc - tr[0];
        tf[j] = cyc;
      end
      if (!p_s[j] && s[j]) tr[j] = cyc;
    end
    if (!s[4]) cs_seen = ~chip_select_n;
    if (ext_address != p_ad && na < 8) begin
      t_ad[na] = cyc;
      na++;
    end
    if (rd_valid === 1'b1) rdq[rd_index] = rd_data;
    p_s = s;
    p_ad = ext_address;
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] mem_word(input logic [25:0] a);
    return a[15:0] ^ 16'ha5c3;
  endfunction
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_acc(input logic w, input logic [1:0] cs, input logic [25:0] a, input logic [1:0] bm);
    int i;
    for (i = 0; i < 300 && req_ready !== 1'b1; i++) @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_cs <= cs;
    req_addr <= a;
    req_burst_m1 <= bm;
    na = 0;
    rdq = '{default: 'x};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    if (i < 300) for (i = 0; i < 300 && access_done !== 1'b1; i++) @(posedge clk_sys);
    if (i == 300) begin
      fail_count++;
      test_done();
    end else repeat (4) @(posedge clk_sys);
  endtask
  // scale is cs[0]+1, half-cycle delays only on select 1
  task automatic chk_rd(input logic [1:0] cs, input logic [1:0] bm, input logic [25:0] a);
    int u, h, n;
    u = 2 * (cs[0] + 1);
    h = (cs == 2'h1);
    n = bm;
    do_acc(1'b0, cs, a, bm);
    chk(cs_seen, 4'h1 << cs);
    chk(tr[4] - tf[4], (7 + 2 * n) * u);
    chk(tf[3] - tf[4], -h);
    chk(tr[3] - tf[4], 2 * u - h);
    chk(tf[2] - tf[4], u);
    chk(tr[2] - tf[4], (7 + 2 * n) * u);
    chk(tr[0] - tf[0], (9 + 2 * n) * u);
    chk(tf[4] - tf[0], u + h);
    for (int k = 0; k <= n; k++) chk(rdq[k], mem_word(a + k));
    if (n == 3) for (int k = 1; k < 3; k++) chk(t_ad[k+1] - t_ad[k], 2 * u);
  endtask
  task automatic chk_wr(input logic [1:0] cs, input logic [1:0] bm, input logic [25:0] a);
    int u, h, n;
    u = 2 * (cs[0] + 1);
    h = (cs == 2'h1);
    n = bm;
    do_acc(1'b1, cs, a, bm);
    chk(tr[4] - tf[4], (6 + 2 * n) * u);
    chk(tr[3] - tf[4], 2 * u - h);
    chk(tf[1] - tf[4], u);
    chk(tr[1] - tf[4], 5 * u);
    chk(tr[0] - tf[0], (8 + 2 * n) * u);
    if (n == 0) chk(wr_data, 16'h1111);
  endtask
  task automatic sc_single_read();
    chk_rd(2'h0, 2'h0, 26'h100);
    chk_rd(2'h1, 2'h0, 26'h2a5);
  endtask
  task automatic sc_page_read();
    chk_rd(2'h2, 2'h3, 26'h3f0);
  endtask
  task automatic sc_writes();
    chk_wr(2'h3, 2'h0, 26'h40);
    chk_wr(2'h1, 2'h0, 26'h51);
    chk_wr(2'h0, 2'h3, 26'h60);
  endtask
  task automatic sc_back_to_back();
    chk_rd(2'h3, 2'h0, 26'h77);
    chk_rd(2'h3, 2'h1, 26'h78);
    chk(gap_seen >= 32, 1);
  endtask
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_cs = 2'h0;
    req_addr = 26'h0;
    req_burst_m1 = 2'h0;
    req_byte_en = 2'h3;
    req_wdata = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
    for (int k = 0; k < 4; k++) cfg[k] = '{5'h01, 5'h08, 5'h07, k == 1, 5'h01, 5'h03, 5'h03, 1'h0, 5'h02,
      5'h08, k == 1, 5'h02, 5'h06, k == 1, 5'h02, {1'h0, k[0]}, 5'h08, 5'h09, 5'h08, 5'h06, 2'h0};
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sc_single_read();
    sc_page_read();
    sc_writes();
    sc_back_to_back();
    test_done();
  end
endmodule
`default_nettype wire
